// ---- sssb_dur_counter.sv ----
// Counts time units up to a programmed target.
// Assumes restart and tick come from logic on sys_clk.
`timescale 1ns/100ps
module sssb_dur_counter #(
  parameter int WIDTH = 11
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic restart,
  input wire logic tick,
  input wire logic [WIDTH-1:0] target,
  output logic done
);
  logic [WIDTH-1:0] count_reg;

  // Saturating count of units since restart
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= '0;
    end else if (restart) begin
      count_reg <= '0;
    end else if (tick && !done) begin
      count_reg <= count_reg + 1'b1;
    end
  end

  assign done = (count_reg >= target);
endmodule : sssb_dur_counter

// ---- sssb_host_model.sv ----
// Host model driving serial setting words and the sweep pin.
// Assumes sys_clk paces it; every change lands at a falling edge.
`timescale 1ns/100ps
module sssb_host_model (
  input wire logic sys_clk,
  output logic sclk,
  output logic sdata,
  output logic frameSyncN,
  output logic sweepControlPin
);
  // Idle pins: serial clock parked high, frame and pin inactive
  initial begin
    sclk = 1'b1;
    sdata = 1'b0;
    frameSyncN = 1'b1;
    sweepControlPin = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : tick
  // Top nbits of a word, MSB first; a short frame is an abort
  task automatic sendWord(input logic [15:0] w, input int nbits);
    frameSyncN = 1'b0;
    for (int i = 15; i > 15 - nbits; i--) begin
      sdata = w[i];
      tick(4);
      sclk = 1'b0;
      tick(4);
      sclk = 1'b1;
    end
    tick(4);
    frameSyncN = 1'b1;
    sdata = ~sdata;
    tick(4);
  endtask : sendWord
  // A rise starts or steps; the high time gates output
  task automatic pulse(input int hi, input int lo);
    sweepControlPin = 1'b1;
    tick(hi);
    sweepControlPin = 1'b0;
    tick(lo);
  endtask : pulse
endmodule : sssb_host_model

// ---- sssb_pkg.sv ----
// Package of constants for the sweep step burst sequencer.
// Assumes one 50 MHz master clock and 16-bit serial words.
package sssb_pkg;
  // Serial word layout
  localparam int WORD_BITS = 16;
  localparam logic [3:0] CMD_STEP_COUNT = 4'h1;
  localparam logic [1:0] CMD_INTERVAL = 2'h1;
  localparam logic [2:0] CMD_BURST = 3'h4;
  // Field positions
  localparam int UNIT_BIT = 13;
  localparam int MULT_HI = 12;
  localparam int MULT_LO = 11;
  localparam int COUNT_HI = 10;
  // Widths
  localparam int STEP_W = 12;
  localparam int SETTING_W = 14;
  localparam int DUR_W = 11;
  localparam int FREQ_W = 24;
  localparam int DAC_W = 10;
  localparam int PRE_W = 9;
  // Time-base multipliers, in master clock periods
  localparam logic [PRE_W-1:0] MULT_X1 = 9'h001;
  localparam logic [PRE_W-1:0] MULT_X5 = 9'h005;
  localparam logic [PRE_W-1:0] MULT_X100 = 9'h064;
  localparam logic [PRE_W-1:0] MULT_X500 = 9'h1F4;
  // Values after reset
  localparam logic [STEP_W-1:0] STEP_COUNT_RST = 12'h002;
  localparam logic [SETTING_W-1:0] SETTING_RST = 14'h2002;
  localparam logic [DAC_W-1:0] MIDSCALE = 10'h200;
  // Synchroniser depth
  localparam int SYNC_STAGES = 2;
  // Sequencer states
  typedef enum logic {SSSB_IDLE, SSSB_RUN} sssb_state_t;
endpackage : sssb_pkg

// ---- sssb_seq_properties.sv ----
// Port checker for the sweep step burst sequencer.
// Assumes sys_clk alone, with rst_n asynchronous and active low.
`timescale 1ns/100ps
module sssb_seq_properties (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic sweepControlPin,
  input wire logic continuousOrBurstSel,
  input wire logic burstSourceSel,
  input wire logic incrementSourceSel,
  input wire logic [23:0] startFrequency,
  input wire logic [23:0] freqIncrement,
  input wire logic [23:0] currentFreq,
  input wire logic [23:0] phaseOut,
  input wire logic [9:0] dacCode,
  input wire logic waveActive,
  input wire logic sweepActive,
  input wire logic stepPulse
);
  wire logic extMode;
  // Fully external timing selected
  assign extMode = !continuousOrBurstSel && burstSourceSel && incrementSourceSel;
  default clocking dc @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  // Gating, stepping and start of the sweep
  mid_scale_a: assert property (!waveActive |-> dacCode == sssb_pkg::MIDSCALE)
    else $error("dac not midscale while gated");
  dac_code_a: assert property (waveActive |-> dacCode == $past(phaseOut[23:14]))
    else $error("dac code not taken from phase");
  pulse_width_a: assert property (stepPulse |=> !stepPulse)
    else $error("step pulse longer than one cycle");
  freq_step_a: assert property ($rose(stepPulse) |-> currentFreq == $past(currentFreq, 2) + $past(freqIncrement, 2))
    else $error("step did not add the increment");
  start_freq_a: assert property ($rose(sweepActive) |-> currentFreq == startFrequency)
    else $error("sweep did not begin at start value");
  phase_acc_a: assert property (continuousOrBurstSel && sweepActive && $past(sweepActive)
    |-> phaseOut == $past(phaseOut) + $past(currentFreq))
    else $error("phase accumulator off");
  cont_out_a: assert property (continuousOrBurstSel && sweepActive && $past(sweepActive, 2) |-> waveActive)
    else $error("continuous output gated");
  idle_hold_a: assert property (!sweepActive && !$past(sweepActive) |-> $stable(currentFreq))
    else $error("frequency moved while idle");
  ext_low_a: assert property ((!sweepControlPin) [*8] ##0 (extMode && sweepActive) |-> !waveActive)
    else $error("output shown while pin low");
  ext_high_a: assert property (sweepControlPin [*8] ##0 (extMode && sweepActive) |-> waveActive)
    else $error("output gated while pin high");
  // Main scenarios reached
  cover property ($rose(stepPulse));
  cover property ($fell(sweepActive));
  cover property (extMode && sweepActive && !waveActive);
  cover property (!continuousOrBurstSel && !incrementSourceSel && sweepActive && !waveActive);
endmodule : sssb_seq_properties

bind sssb_sequencer sssb_seq_properties props (.sys_clk, .rst_n, .sweepControlPin, .continuousOrBurstSel,
  .burstSourceSel, .incrementSourceSel, .startFrequency, .freqIncrement, .currentFreq, .phaseOut, .dacCode,
  .waveActive, .sweepActive, .stepPulse);

// ---- sssb_sequencer.sv ----
// Sweep step burst sequencer: settings, step timing and burst gating.
// Assumes start frequency, increment and control bits arrive from
// other logic on sys_clk; the serial pins and sweep pin are asynchronous.
`timescale 1ns/100ps
module sssb_sequencer (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic sdata,
  input wire logic frameSyncN,
  input wire logic sweepControlPin,
  input wire logic continuousOrBurstSel,
  input wire logic burstSourceSel,
  input wire logic incrementSourceSel,
  input wire logic [23:0] startFrequency,
  input wire logic [23:0] freqIncrement,
  output logic [23:0] currentFreq,
  output logic [23:0] phaseOut,
  output logic [9:0] dacCode,
  output logic waveActive,
  output logic sweepActive,
  output logic stepPulse
);
  // Settings written over the serial port
  logic [sssb_pkg::STEP_W-1:0] increment_count_reg;
  logic [sssb_pkg::SETTING_W-1:0] step_interval_setting_reg;
  logic [sssb_pkg::SETTING_W-1:0] burst_length_setting_reg;

  // Sweep pin synchroniser and edge detector
  logic ctrlMeta_reg;
  logic ctrlSync_reg;
  logic ctrlPrev_reg;
  logic ctrlRise;

  // Sequencer state
  sssb_pkg::sssb_state_t state_reg;
  sssb_pkg::sssb_state_t state_next;
  logic [sssb_pkg::STEP_W-1:0] stepIdx_reg;
  logic [23:0] freq_reg;
  logic [23:0] acc_reg;
  logic accWrap;
  logic [24:0] accSum;

  // Time base
  logic [sssb_pkg::PRE_W-1:0] pre_reg;
  logic [sssb_pkg::PRE_W-1:0] multValue;
  logic [1:0] multSel;
  logic unitClock;
  logic preTick;
  logic unitTick;

  // Mode and step decisions
  logic extIncr;
  logic extBurst;
  logic burstMode;
  logic stepEvent;
  logic lastStep;
  logic advance;
  logic startSweep;
  logic endSweep;
  logic restartCount;
  logic intervalDone;
  logic burstDone;
  logic outputOn;
  logic autoStep;
  logic [sssb_pkg::DUR_W-1:0] intervalTarget;

  // Registered outputs
  logic [9:0] dac_reg;
  logic active_reg;
  logic stepPulse_reg;

  sssb_word_if wordBus ();

  // Serial receiver for setting words
  sssb_serial_rx u_rx (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .sclk(sclk),
    .sdata(sdata),
    .frameSyncN(frameSyncN),
    .wordBus(wordBus.rx)
  );

  // Decode of setting words by their prefix
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      increment_count_reg <= sssb_pkg::STEP_COUNT_RST;
      step_interval_setting_reg <= sssb_pkg::SETTING_RST;
      burst_length_setting_reg <= sssb_pkg::SETTING_RST;
    end else if (wordBus.valid) begin
      if (wordBus.word[15:12] == sssb_pkg::CMD_STEP_COUNT) begin
        increment_count_reg <= wordBus.word[11:0];
      end
      if (wordBus.word[15:14] == sssb_pkg::CMD_INTERVAL) begin
        step_interval_setting_reg <= wordBus.word[13:0];
      end
      if (wordBus.word[15:13] == sssb_pkg::CMD_BURST) begin
        burst_length_setting_reg <= wordBus.word[13:0];
      end
    end
  end

  // Two flip-flops before the sweep pin is used, then an edge stage
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrlMeta_reg <= 1'b0;
      ctrlSync_reg <= 1'b0;
      ctrlPrev_reg <= 1'b0;
    end else begin
      ctrlMeta_reg <= sweepControlPin;
      ctrlSync_reg <= ctrlMeta_reg;
      ctrlPrev_reg <= ctrlSync_reg;
    end
  end

  // Rising edge of the synchronised pin; the reset levels match the idle low
  // pin, so no false rise follows reset
  assign ctrlRise = ctrlSync_reg & ~ctrlPrev_reg;

  // Mode decode; burst source only counts with external increments
  // A burst source of one without external increments acts as automatic
  assign extIncr = incrementSourceSel;
  assign extBurst = incrementSourceSel & burstSourceSel;
  assign burstMode = ~continuousOrBurstSel;

  // Unit and multiplier come from interval, or burst word when stepped
  always_comb begin
    if (extIncr && !extBurst) begin
      unitClock = burst_length_setting_reg[sssb_pkg::UNIT_BIT];
      multSel = burst_length_setting_reg[sssb_pkg::MULT_HI:sssb_pkg::MULT_LO];
    end else begin
      unitClock = step_interval_setting_reg[sssb_pkg::UNIT_BIT];
      multSel = step_interval_setting_reg[sssb_pkg::MULT_HI:sssb_pkg::MULT_LO];
    end
  end

  // Multiplier table for the base interval
  always_comb begin
    case (multSel)
      2'h0: multValue = sssb_pkg::MULT_X1;
      2'h1: multValue = sssb_pkg::MULT_X5;
      2'h2: multValue = sssb_pkg::MULT_X100;
      2'h3: multValue = sssb_pkg::MULT_X500;
      default: multValue = sssb_pkg::MULT_X1;
    endcase
  end

  // Prescaler giving one tick per base interval of master clocks
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_reg <= '0;
    end else if (restartCount || preTick) begin
      pre_reg <= '0;
    end else begin
      pre_reg <= pre_reg + 9'h001;
    end
  end

  assign preTick = (pre_reg >= multValue - 9'h001);

  // Phase accumulator at the current step frequency
  assign accSum = {1'b0, acc_reg} + {1'b0, freq_reg};
  assign accWrap = accSum[24];

  // Cleared at start so every sweep begins at phase zero; left running
  // across steps so each frequency change is phase continuous
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_reg <= 24'h000000;
    end else if (startSweep) begin
      acc_reg <= 24'h000000;
    end else if (state_reg == sssb_pkg::SSSB_RUN) begin
      acc_reg <= accSum[23:0];
    end
  end

  // One unit is an output cycle or a base interval
  assign unitTick = unitClock ? preTick : accWrap;

  // The interval counter stops one unit short of the setting and the step
  // fires on the unit that completes it: a count of N then holds a frequency
  // for N units, not N plus the restart cycle
  assign intervalTarget = step_interval_setting_reg[sssb_pkg::COUNT_HI:0] - 11'h001;

  // Step interval counter, up to 2047 units
  sssb_dur_counter #(
    .WIDTH(sssb_pkg::DUR_W)
  ) u_interval (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .restart(restartCount),
    .tick(unitTick),
    .target(intervalTarget),
    .done(intervalDone)
  );

  // Burst length counter, same units as the interval
  // It saturates, so midscale holds until the counters restart
  sssb_dur_counter #(
    .WIDTH(sssb_pkg::DUR_W)
  ) u_burst (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .restart(restartCount),
    .tick(unitTick),
    .target(burst_length_setting_reg[sssb_pkg::COUNT_HI:0]),
    .done(burstDone)
  );

  // Automatic step on the unit that completes the interval count
  assign autoStep = intervalDone & unitTick;

  // Step events: timer in automatic mode, pin edge when stepped outside
  always_comb begin
    if (state_reg != sssb_pkg::SSSB_RUN) begin
      stepEvent = 1'b0;
    end else if (extIncr) begin
      stepEvent = ctrlRise;
    end else begin
      stepEvent = autoStep;
    end
  end

  // The final period ends the sweep: count plus one periods in all
  assign lastStep = (stepIdx_reg == increment_count_reg);
  assign advance = stepEvent & ~lastStep;
  assign endSweep = stepEvent & lastStep;
  assign startSweep = (state_reg == sssb_pkg::SSSB_IDLE) & ctrlRise;
  assign restartCount = startSweep | advance;

  // Next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      sssb_pkg::SSSB_IDLE: begin
        if (startSweep) begin
          state_next = sssb_pkg::SSSB_RUN;
        end
      end
      sssb_pkg::SSSB_RUN: begin
        if (endSweep) begin
          state_next = sssb_pkg::SSSB_IDLE;
        end
      end
      default: state_next = sssb_pkg::SSSB_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= sssb_pkg::SSSB_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Frequency and step index; no stop value is held
  // A negative increment wraps in two's complement and sweeps downward
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      freq_reg <= 24'h000000;
      stepIdx_reg <= '0;
    end else if (startSweep) begin
      freq_reg <= startFrequency;
      stepIdx_reg <= '0;
    end else if (advance) begin
      freq_reg <= freq_reg + freqIncrement;
      stepIdx_reg <= stepIdx_reg + 12'h001;
    end
  end

  // Whether the waveform or midscale is shown
  always_comb begin
    if (state_reg != sssb_pkg::SSSB_RUN) begin
      outputOn = 1'b0;
    end else if (!burstMode) begin
      outputOn = 1'b1;
    end else if (extBurst) begin
      outputOn = ctrlSync_reg;
    end else begin
      outputOn = ~burstDone;
    end
  end

  // Registered waveform code, midscale outside the burst
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dac_reg <= sssb_pkg::MIDSCALE;
      active_reg <= 1'b0;
    end else begin
      active_reg <= outputOn;
      if (outputOn) begin
        dac_reg <= acc_reg[23:14];
      end else begin
        dac_reg <= sssb_pkg::MIDSCALE;
      end
    end
  end

  // One-cycle mark of each frequency increment
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stepPulse_reg <= 1'b0;
    end else begin
      stepPulse_reg <= advance;
    end
  end

  // Outputs
  assign currentFreq = freq_reg;
  assign phaseOut = acc_reg;
  assign dacCode = dac_reg;
  assign waveActive = active_reg;
  assign sweepActive = (state_reg == sssb_pkg::SSSB_RUN);
  assign stepPulse = stepPulse_reg;
endmodule : sssb_sequencer

// ---- sssb_serial_rx.sv ----
// Framed serial receiver for setting words.
// Assumes sclk runs well below sys_clk so synchronised edges are seen.
`timescale 1ns/100ps
module sssb_serial_rx (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic sdata,
  input wire logic frameSyncN,
  sssb_word_if.rx wordBus
);
  logic [2:0] meta_reg;
  logic [2:0] sync_reg;
  logic sclkPrev_reg;
  logic [15:0] shift_reg;
  logic [4:0] bitCount_reg;
  logic [15:0] word_reg;
  logic valid_reg;
  logic fallEdge;

  // Two-stage synchroniser for sclk, sdata and frame sync
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= 3'h7;
      sync_reg <= 3'h7;
      sclkPrev_reg <= 1'b1;
    end else begin
      meta_reg <= {sclk, sdata, frameSyncN};
      sync_reg <= meta_reg;
      sclkPrev_reg <= sync_reg[2];
    end
  end

  // Data is taken on the falling sclk edge
  assign fallEdge = sclkPrev_reg & ~sync_reg[2];

  // Shift in MSB first while the frame is low
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= 16'h0000;
      bitCount_reg <= 5'h00;
      word_reg <= 16'h0000;
      valid_reg <= 1'b0;
    end else begin
      valid_reg <= 1'b0;
      if (sync_reg[0]) begin
        bitCount_reg <= 5'h00;
      end else if (fallEdge) begin
        shift_reg <= {shift_reg[14:0], sync_reg[1]};
        if (bitCount_reg == 5'h0F) begin
          word_reg <= {shift_reg[14:0], sync_reg[1]};
          valid_reg <= 1'b1;
          bitCount_reg <= 5'h00;
        end else begin
          bitCount_reg <= bitCount_reg + 5'h01;
        end
      end
    end
  end

  assign wordBus.word = word_reg;
  assign wordBus.valid = valid_reg;
endmodule : sssb_serial_rx

// ---- sssb_word_if.sv ----
// Interface carrying received 16-bit setting words.
// Assumes the receiver and sequencer share sys_clk.
`timescale 1ns/100ps
interface sssb_word_if;
  logic [15:0] word;
  logic valid;
  modport rx (output word, output valid);
  modport seq (input word, input valid);
endinterface : sssb_word_if

// ---- tb.sv ----
// Self-checking bench for the sweep step burst sequencer.
// Assumes the host model, the bound checker and a 50 MHz clock.
`timescale 1ns/100ps
module tb;
  typedef struct {logic [23:0] freq; int gap; int burst;} sssb_exp_t;
  logic sys_clk, rst_n, contSel, burstSrc, incSrc, sclk, sdata, frameSyncN, sweepControlPin;
  logic waveActive, sweepActive, stepPulse;
  logic swPrev = 1'b0;
  logic [23:0] startFrequency, freqIncrement, currentFreq;
  logic [31:0] seed;
  int failCount, testsRun, gapCnt, hiCnt, durCnt;
  int cv[6] = '{2, 2, 2, 3, 3, 4095};
  int nv[6] = '{3, 3, 3, 3, 2047, 2};
  int mc[6] = '{0, 1, 2, 3, 0, 0};
  int mul[4] = '{1, 5, 100, 500};
  sssb_exp_t expQ[$];
  sssb_exp_t e;
  sssb_sequencer dut (.sys_clk, .rst_n, .sclk, .sdata, .frameSyncN, .sweepControlPin,
    .continuousOrBurstSel(contSel), .burstSourceSel(burstSrc), .incrementSourceSel(incSrc), .startFrequency,
    .freqIncrement, .currentFreq, .phaseOut(), .dacCode(), .waveActive, .sweepActive, .stepPulse);
  sssb_host_model host (.sys_clk, .sclk, .sdata, .frameSyncN, .sweepControlPin);
  // 50 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      failCount++;
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : check
  task automatic testDone();
    $display("checks %0d mismatches %0d", testsRun, failCount);
    if (failCount == 0 && testsRun > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : testDone
  // Step monitor: oldest note against each step pulse
  always @(posedge sys_clk) begin
    swPrev <= sweepActive;
    durCnt <= (sweepActive && !swPrev) ? 1 : durCnt + int'(sweepActive);
    if (stepPulse || (sweepActive && !swPrev)) begin
      gapCnt <= 1;
      hiCnt <= int'(waveActive);
    end else begin
      gapCnt <= gapCnt + 1;
      hiCnt <= hiCnt + int'(waveActive);
    end
    if (stepPulse) begin
      if (expQ.size() == 0) begin
        check(32'h1, 32'h0);
      end else begin
        e = expQ.pop_front();
        check(currentFreq, e.freq);
        if (e.gap != 0) check(gapCnt, e.gap);
        if (e.burst != 0) check((hiCnt - e.burst) ** 2 <= 1 ? e.burst : hiCnt, e.burst);
      end
    end
  end
  // Programs one sweep, notes its steps and runs it to the end
  task automatic sweep(input logic [2:0] mode, input logic [15:0] iw, input logic [15:0] bw, input int cnt,
                       input int gap, input int bst, input int hi, input int m);
    int t;
    t = 0;
    @(negedge sys_clk);
    {contSel, burstSrc, incSrc} = mode;
    host.sendWord({4'h1, cnt[11:0]}, 16);
    host.sendWord(iw, 16);
    host.sendWord(bw, 16);
    host.sendWord(16'h1007, 8);
    host.sendWord(16'hC007, 16);
    for (int k = 1; k <= cnt; k++) expQ.push_back('{24'(startFrequency + k * freqIncrement), (k > 1) ? gap : 0, bst});
    if (hi == 0) host.pulse(4, 4);
    else repeat (cnt + 2) host.pulse(hi, gap - hi);
    while (sweepActive && t < 50000) begin
      @(negedge sys_clk);
      t++;
    end
    repeat (4) @(negedge sys_clk);
    check(expQ.size(), 0);
    check(sweepActive, 1'b0);
    check((durCnt - (cnt + 1) * gap) ** 2 <= (m + 3) ** 2, 1'b1);
  endtask : sweep
  // Reset, then continuous, automatic burst, stepped burst and fully external sweeps in turn
  initial begin
    seed = 32'hADE0;
    failCount = 0;
    testsRun = 0;
    {rst_n, contSel, burstSrc, incSrc} = 4'h8 ^ 4'h8;
    startFrequency = 24'h000000;
    freqIncrement = 24'h000000;
    repeat (10) @(negedge sys_clk);
    rst_n = 1'b1;
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      startFrequency = seed[23:0];
      seed = lfsr(seed);
      freqIncrement = seed[23:0];
      sweep(3'b100, {3'b011, mc[i][1:0], nv[i][10:0]}, 16'h8002, cv[i], nv[i] * mul[mc[i]], 0, 0, mul[mc[i]]);
    end
    startFrequency = 24'h200000;
    freqIncrement = 24'h000000;
    sweep(3'b100, 16'h4002, 16'h8002, 2, 16, 0, 0, 0);
    freqIncrement = 24'hFFFF00;
    sweep(3'b000, 16'h6014, 16'h8005, 2, 20, 5, 0, 1);
    startFrequency = 24'h800000;
    freqIncrement = 24'h000000;
    sweep(3'b001, 16'h7007, 16'h8003, 2, 100, 6, 4, 0);
    seed = lfsr(seed);
    freqIncrement = seed[23:0];
    sweep(3'b011, 16'h7FFF, 16'h9FFF, 3, 40, 10, 10, 0);
    testDone();
  end
  // Watchdog
  initial begin
    repeat (80000) @(posedge sys_clk);
    failCount++;
    testDone();
  end
endmodule : tb
